// ===== pep_port_parity.sv
// Overview of operation
// [RULE1] Check-disable set: no receive parity check, no flag, no report.
// [RULE2] Parity is always generated on data sent to the core.
// [RULE3] Inject set and header length byte matches: every dword parity inverted.
// [RULE4] Parity error sets status bit 0; write one clears, zero keeps.
// [RULE5] Report field selects none, ERR_COR, ERR_NONFATAL, ERR_FATAL; resets to 2.
// [RULE6] Message sent only when status bit rises from zero to one.
// [RULE7] Interrupt enable plus upstream int/MSI enable gives an INT/MSI request.
// [RULE8] Sticky control fields survive warm reset, clear only on power-on.
`timescale 1ns/10ps
`include "pep_params.svh"

module pep_port_parity #(
  parameter int DATA_W = 32
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   por_n_i,
  // Register port
  input  wire logic [`PEP_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // Egress toward switch core
  input  wire logic                   tx_valid_i,
  input  wire logic                   tx_sop_i,
  input  wire logic [DATA_W-1:0]      tx_data_i,
  output logic                        tx_valid_o,
  output logic      [DATA_W-1:0]      tx_data_o,
  output logic                        tx_parity_o,
  // Ingress from switch core
  input  wire logic                   rx_valid_i,
  input  wire logic [DATA_W-1:0]      rx_data_i,
  input  wire logic                   rx_parity_i,
  // Reporting
  input  wire logic                   up_int_en_i,
  output logic                        err_msg_valid_o,
  output pep_pkg::pep_msg_e           err_msg_type_o,
  output logic                        int_req_o,
  output logic                        irq_o
);

  // Sticky control: reset only by power-on
  logic       chk_dis, next_chk_dis;
  logic       inj_en, next_inj_en;
  logic [7:0] match_len, next_match_len;
  // Warm-reset state
  logic       perr, next_perr;
  logic [1:0] rpt_sel, next_rpt_sel;
  logic       irq_en, next_irq_en;
  logic       irq_mask, next_irq_mask;
  logic       in_bad_tlp, next_in_bad_tlp;
  logic [31:0] next_rdata;
  logic        next_tx_valid;
  logic [DATA_W-1:0] next_tx_data;
  logic        next_tx_parity;
  logic        next_msg_valid;
  pep_pkg::pep_msg_e next_msg_type;
  logic        next_int_req;
  logic        next_irq;

  logic wr_ctl, wr_sts, wr_rpt, wr_msk, detect, bad_now;

  always_comb begin
    wr_ctl = reg_wr_i && (reg_addr_i == `PEP_OFF_CTL);
    wr_sts = reg_wr_i && (reg_addr_i == `PEP_OFF_STS);
    wr_rpt = reg_wr_i && (reg_addr_i == `PEP_OFF_RPT);
    wr_msk = reg_wr_i && (reg_addr_i == `PEP_OFF_IRQ_MASK);
    next_chk_dis   = wr_ctl ? reg_wdata_i[`PEP_CTL_CHKDIS_BIT] : chk_dis;
    next_inj_en    = wr_ctl ? reg_wdata_i[`PEP_CTL_INJ_BIT] : inj_en;
    next_match_len = wr_ctl ? reg_wdata_i[`PEP_CTL_LEN_MSB:`PEP_CTL_LEN_LSB] : match_len;
  end

  always_ff @(posedge clock_i) begin
    if (!por_n_i) begin
      chk_dis   <= `PEP_RST_CHK_DIS; // RULE8
      inj_en    <= `PEP_RST_INJ;
      match_len <= `PEP_RST_MATCH_LEN;
    end else begin
      chk_dis   <= next_chk_dis; // RULE8
      inj_en    <= next_inj_en;
      match_len <= next_match_len;
    end
  end

  // Egress: header byte zero is the top byte of the first dword
  always_comb begin
    bad_now = tx_sop_i ? (inj_en && (tx_data_i[DATA_W-1 -: 8] == match_len))
                       : in_bad_tlp; // RULE3
    next_in_bad_tlp = (tx_valid_i && tx_sop_i) ? bad_now : in_bad_tlp;
    next_tx_valid   = tx_valid_i;
    next_tx_data    = tx_data_i;
    // Inversion rather than gating keeps generation always on
    next_tx_parity  = (^tx_data_i) ^ (tx_valid_i && bad_now); // RULE2 RULE3
  end

  // Checking and reporting
  always_comb begin
    detect = rx_valid_i && !chk_dis && ((^rx_data_i) != rx_parity_i); // RULE1
    next_perr = detect || (perr && !(wr_sts && reg_wdata_i[`PEP_STS_PERR_BIT])); // RULE4
    next_rpt_sel  = wr_rpt ? reg_wdata_i[`PEP_RPT_SEL_MSB:`PEP_RPT_SEL_LSB] : rpt_sel;
    next_irq_en   = wr_rpt ? reg_wdata_i[`PEP_RPT_IRQEN_BIT] : irq_en;
    next_irq_mask = wr_msk ? reg_wdata_i[`PEP_STS_PERR_BIT] : irq_mask;
    // Rising edge of the flag only; a clear and fresh error in one cycle keeps it set
    next_msg_valid = detect && !perr && (rpt_sel != 2'h0); // RULE5 RULE6
    next_msg_type  = pep_pkg::pep_msg_e'(rpt_sel); // RULE5
    next_int_req   = detect && irq_en && up_int_en_i; // RULE7
    next_irq       = next_perr && irq_mask;
    next_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `PEP_OFF_CTL: begin
          next_rdata[`PEP_CTL_CHKDIS_BIT] = chk_dis;
          next_rdata[`PEP_CTL_INJ_BIT]    = inj_en;
          next_rdata[`PEP_CTL_LEN_MSB:`PEP_CTL_LEN_LSB] = match_len;
        end
        `PEP_OFF_STS: next_rdata[`PEP_STS_PERR_BIT] = perr;
        `PEP_OFF_RPT: begin
          next_rdata[`PEP_RPT_SEL_MSB:`PEP_RPT_SEL_LSB] = rpt_sel;
          next_rdata[`PEP_RPT_IRQEN_BIT] = irq_en;
        end
        `PEP_OFF_IRQ_MASK: next_rdata[`PEP_STS_PERR_BIT] = irq_mask;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !por_n_i) begin
      perr            <= `PEP_RST_STS;
      rpt_sel         <= `PEP_RST_RPT_SEL; // RULE5
      irq_en          <= `PEP_RST_RPT_IRQEN;
      irq_mask        <= `PEP_RST_IRQ_MASK;
      in_bad_tlp      <= 1'b0;
      reg_rdata_o     <= 32'h0000_0000;
      tx_valid_o      <= 1'b0;
      tx_data_o       <= '0;
      tx_parity_o     <= 1'b0;
      err_msg_valid_o <= 1'b0;
      err_msg_type_o  <= pep_pkg::PEP_MSG_NONE;
      int_req_o       <= 1'b0;
      irq_o           <= 1'b0;
    end else begin
      perr            <= next_perr;
      rpt_sel         <= next_rpt_sel;
      irq_en          <= next_irq_en;
      irq_mask        <= next_irq_mask;
      in_bad_tlp      <= next_in_bad_tlp;
      reg_rdata_o     <= next_rdata;
      tx_valid_o      <= next_tx_valid;
      tx_data_o       <= next_tx_data;
      tx_parity_o     <= next_tx_parity;
      err_msg_valid_o <= next_msg_valid;
      err_msg_type_o  <= next_msg_type;
      int_req_o       <= next_int_req;
      irq_o           <= next_irq;
    end
  end

endmodule // pep_port_parity

// ===== pep_params.svh
`ifndef PEP_PARAMS_SVH
`define PEP_PARAMS_SVH

`define PEP_ADDR_W          12
`define PEP_OFF_CTL         12'h4D4
`define PEP_OFF_STS         12'h4D8
`define PEP_OFF_RPT         12'h4DC
`define PEP_OFF_IRQ_MASK    12'h4E4

`define PEP_CTL_CHKDIS_BIT  0
`define PEP_CTL_INJ_BIT     1
`define PEP_CTL_LEN_LSB     8
`define PEP_CTL_LEN_MSB     15
`define PEP_STS_PERR_BIT    0
`define PEP_RPT_SEL_LSB     0
`define PEP_RPT_SEL_MSB     1
`define PEP_RPT_IRQEN_BIT   2

`define PEP_RST_CTL         32'h0000_0000
`define PEP_RST_CHK_DIS     1'b0
`define PEP_RST_INJ         1'b0
`define PEP_RST_MATCH_LEN   8'h00
`define PEP_RST_STS         1'b0
`define PEP_RST_RPT_SEL     2'h2
`define PEP_RST_RPT_IRQEN   1'b0
`define PEP_RST_IRQ_MASK    1'b0

`endif

// ===== pep_pkg.sv
package pep_pkg;
  typedef enum logic [1:0] {
    PEP_MSG_NONE     = 2'h0,
    PEP_MSG_COR      = 2'h1,
    PEP_MSG_NONFATAL = 2'h2,
    PEP_MSG_FATAL    = 2'h3
  } pep_msg_e;
endpackage

// ===== pep_port_parity_asserts.sv
`timescale 1ns/10ps
module pep_port_parity_asserts #(parameter int DATA_W = 32) (
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic              por_n_i,
  input wire logic              tx_valid_i,
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic              tx_valid_o,
  input wire logic [DATA_W-1:0] tx_data_o,
  input wire logic              rx_valid_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  input wire logic              rx_parity_i,
  input wire logic              up_int_en_i,
  input wire logic              err_msg_valid_o,
  input wire pep_pkg::pep_msg_e err_msg_type_o,
  input wire logic              int_req_o
);
  // Raw mismatch on the wire; check-disable is invisible here, so only necessity is asserted
  wire e = rx_valid_i && (^rx_data_i != rx_parity_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !por_n_i);
  sequence s_rpt; err_msg_valid_o ##1 e; endsequence
  property p_tv; tx_valid_i |=> tx_valid_o && tx_data_o == $past(tx_data_i); endproperty
  property p_ti; !tx_valid_i |=> !tx_valid_o; endproperty
  property p_mc; err_msg_valid_o |-> $past(e); endproperty
  property p_ic; int_req_o |-> $past(e && up_int_en_i); endproperty
  property p_mt; err_msg_valid_o |-> err_msg_type_o != pep_pkg::PEP_MSG_NONE; endproperty
  property p_1p; err_msg_valid_o |=> !err_msg_valid_o; endproperty
  property p_nm; s_rpt |=> !err_msg_valid_o; endproperty
  property p_ok; !e |=> !err_msg_valid_o && !int_req_o; endproperty
  a_tv: assert property (p_tv) else $error("tx copy wrong");
  a_ti: assert property (p_ti) else $error("tx idle wrong");
  a_mc: assert property (p_mc) else $error("message without error");
  a_ic: assert property (p_ic) else $error("interrupt without cause");
  a_mt: assert property (p_mt) else $error("empty message type");
  a_1p: assert property (p_1p) else $error("message too long");
  a_nm: assert property (p_nm) else $error("repeat report");
  a_ok: assert property (p_ok) else $error("report on good word");
endmodule // pep_port_parity_asserts
bind pep_port_parity pep_port_parity_asserts #(.DATA_W(DATA_W)) pep_port_parity_asserts_inst (.*);

// ===== pep_core_model.sv
`timescale 1ns/10ps
module pep_core_model (
  input  wire logic        clock_i,
  input  wire logic        send_i,
  input  wire logic        bad_i,
  input  wire logic [31:0] d_i,
  output logic             rx_valid_o,
  output logic [31:0]      rx_data_o,
  output logic             rx_parity_o
);
  // Idle data toggles so a stale word never looks fresh
  always @(posedge clock_i) begin
    rx_valid_o  <= send_i;
    rx_data_o   <= send_i ? d_i : ~rx_data_o;
    rx_parity_o <= ^d_i ^ bad_i;
  end
endmodule // pep_core_model

// ===== tb.sv
`timescale 1ns/10ps
`include "pep_params.svh"
module tb;
  logic clock_i = 0, rst_n_i = 0, por_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, snd = 0, bad = 0;
  logic tx_valid_i = 0, tx_sop_i = 0, up_int_en_i = 0, rx_valid_i, rx_parity_i, tx_valid_o;
  logic tx_parity_o, err_msg_valid_o, int_req_o, irq_o;
  logic [11:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, tx_data_i = 0, rx_data_i, reg_rdata_o, tx_data_o;
  pep_pkg::pep_msg_e err_msg_type_o;
  int error_cnt = 0, comparisons = 0;
  always #2.5 clock_i = ~clock_i;
  pep_port_parity pep_port_parity_inst (.*);
  pep_core_model pep_core_model_inst (.clock_i, .send_i(snd), .bad_i(bad), .d_i(tx_data_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_parity_o(rx_parity_i));
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clock_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) reg_wr_i <= 0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x);
    @(posedge clock_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clock_i) reg_rd_i <= 0;
    #1 chk("rdata", reg_rdata_o, x);
  endtask
  task automatic rx(logic b, logic [31:0] m, logic [31:0] i);
    @(posedge clock_i) {snd, bad} <= {1'b1, b};
    @(posedge clock_i) snd <= 0;
    @(posedge clock_i) #1 chk("msg", err_msg_valid_o ? {1'b1, err_msg_type_o} : 0, m);
    chk("int_req", int_req_o, i);
  endtask
  task automatic t_tx;
    wr(`PEP_OFF_CTL, 32'h0000_1202);
    // Two TLPs: first matches the length byte, second does not
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i) tx_valid_i <= i < 4;
      tx_sop_i <= !i[0];
      tx_data_i <= {i[1] ? 8'h13 : 8'h12, 24'h00_0f0f} ^ i;
      #1 if (i > 0) chk("parity", tx_parity_o, ^tx_data_o ^ (i < 3));
      if (i > 0) chk("tx_valid", tx_valid_o, 1);
    end
    $display("tx test done");
  endtask
  task automatic t_err;
    @(posedge clock_i) up_int_en_i <= 1;
    for (int s = 0; s < 4; s++) begin
      wr(`PEP_OFF_RPT, 32'h0000_0004 | s);
      wr(`PEP_OFF_STS, 32'h0000_0001);
      rx(1, s ? 4 | s : 0, 1);
      rx(1, 0, 1);
    end
    wr(`PEP_OFF_STS, 32'h0000_0000);
    wr(`PEP_OFF_IRQ_MASK, 32'h0000_0001);
    rd(`PEP_OFF_STS, 1);
    chk("irq", irq_o, 1);
    wr(`PEP_OFF_STS, 32'h0000_0001);
    rd(`PEP_OFF_STS, 0);
    chk("irq", irq_o, 0);
    $display("error test done");
  endtask
  task automatic t_dis;
    wr(`PEP_OFF_CTL, 32'h0000_0001);
    rx(1, 0, 0);
    rd(`PEP_OFF_STS, 0);
    @(posedge clock_i) rst_n_i <= 0;
    @(posedge clock_i) rst_n_i <= 1;
    rd(`PEP_OFF_CTL, 1);
    rd(`PEP_OFF_RPT, 2);
    @(posedge clock_i) por_n_i <= 0;
    @(posedge clock_i) por_n_i <= 1;
    rd(`PEP_OFF_CTL, 0);
    $display("disable test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    {rst_n_i, por_n_i} <= 2'b11;
    rd(`PEP_OFF_RPT, 2);
    t_tx;
    t_err;
    t_dis;
    print_verdict;
  end
  initial begin
    #20000 error_cnt++;
    print_verdict;
  end
endmodule // tb
